// ===== rtl/charger_status_flags.sv
`default_nettype none
module charger_status_flags
    import charger_status_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Two-wire host bus, open drain.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Live charger indications.
    input wire logic input_good_pin,
    input wire logic current_optimise_done,
    input wire logic input_voltage_regulating,
    input wire logic input_current_regulating,
    input wire logic fast_charge_active,
    input wire logic precharge_active,
    input wire logic reverse_supply_active,
    // Fault events.
    input wire logic input_overvoltage_fault,
    input wire logic battery_overcurrent_fault,
    input wire logic input_overcurrent_fault,
    input wire logic latchoff_fault,
    input wire logic reverse_overvoltage_fault,
    input wire logic reverse_overcurrent_fault,
    input wire logic system_overvoltage_detect,
    // Processor throttle triggers.
    input wire logic [TRIGGER_COUNT-1:0] throttle_trigger_in,
    // Power stage control.
    output logic converter_enable
);
    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    logic [SYNC_WIDTH-1:0] raw_in;
    logic [SYNC_WIDTH-1:0] synced;
    logic scl_s;
    logic sda_s;
    logic [15:0] live_word;
    logic [15:0] fault_events;
    logic system_ov_s;
    logic [TRIGGER_COUNT-1:0] trigger_s;

    // Every bus, status and trigger input passes two flip-flops before use; clock, reset and enable do not.
    assign raw_in = {scl_in, sda_in, input_good_pin, current_optimise_done,
        input_voltage_regulating, input_current_regulating, fast_charge_active,
        precharge_active, reverse_supply_active, input_overvoltage_fault,
        battery_overcurrent_fault, input_overcurrent_fault, latchoff_fault,
        reverse_overvoltage_fault, reverse_overcurrent_fault,
        system_overvoltage_detect, throttle_trigger_in};

    input_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .async_in(raw_in),
        .sync_out(synced)
    );

    // Bus, overvoltage and trigger bits.
    assign scl_s = synced[22];
    assign sda_s = synced[21];
    assign system_ov_s = synced[7];
    assign trigger_s = synced[6:0];

    // Place live indications at their word positions.
    always_comb begin
        live_word = 16'h0000;
        live_word[BIT_INPUT_PRESENT] = synced[20];
        live_word[BIT_OPTIMISE_DONE] = synced[19];
        live_word[BIT_VOLTAGE_REG] = synced[18];
        live_word[BIT_CURRENT_REG] = synced[17];
        live_word[BIT_FAST_CHARGE] = synced[16];
        live_word[BIT_PRECHARGE] = synced[15];
        live_word[BIT_REVERSE] = synced[14];
    end

    // Place fault events at their word positions.
    always_comb begin
        fault_events = 16'h0000;
        fault_events[BIT_INPUT_OV] = synced[13];
        fault_events[BIT_BATTERY_OC] = synced[12];
        fault_events[BIT_INPUT_OC] = synced[11];
        fault_events[BIT_LATCHOFF] = synced[10];
        fault_events[BIT_REVERSE_OV] = synced[9];
        fault_events[BIT_REVERSE_OC] = synced[8];
    end

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    status_access_if acc ();

    status_bank u_bank (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .live_word(live_word),
        .fault_events(fault_events),
        .system_ov_detect(system_ov_s),
        .trigger_events(trigger_s),
        .acc(acc.bank),
        .converter_enable(converter_enable)
    );

    // ----------------------------------------------------------------
    // Bus line events
    // ----------------------------------------------------------------
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    // Previous line levels for edge detection.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_prev_q <= 1'b0;
            sda_prev_q <= 1'b0;
        end else if (ce) begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // Start and stop are data changes while the clock line is high.
    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    assign bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign bus_stop = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    // ----------------------------------------------------------------
    // Protocol engine
    // ----------------------------------------------------------------
    // Engine registers.
    bus_state_type state_q;
    logic [3:0] bit_cnt_q;
    logic [1:0] byte_idx_q;
    logic [7:0] shift_q;
    logic [7:0] cmd_q;
    logic [7:0] low_q;
    logic [15:0] tx_q;
    logic [15:0] wdata_q;
    logic reading_q;
    logic second_q;
    logic acked_q;
    logic oe_q;
    logic wr_q;

    // Decoded events.
    logic byte_done;
    logic addr_match;
    logic read_load;

    // A byte is complete at the clock fall after its eighth bit.
    assign byte_done = (state_q == ST_RX) && scl_fall && (bit_cnt_q == BYTE_BITS);
    assign addr_match = shift_q[7:1] == TARGET_ADDR;

    // Read snapshot and flag clear happen on the same edge.
    assign read_load = byte_done && (byte_idx_q == 2'd0) && addr_match && shift_q[0];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            byte_idx_q <= 2'd0;
            shift_q <= 8'h00;
            cmd_q <= 8'h00;
            low_q <= 8'h00;
            tx_q <= 16'h0000;
            wdata_q <= 16'h0000;
            reading_q <= 1'b0;
            second_q <= 1'b0;
            acked_q <= 1'b0;
            oe_q <= 1'b0;
            wr_q <= 1'b0;
        end else if (ce) begin
            wr_q <= 1'b0;

            if (bus_start) begin
                // Start or repeated start: expect an address byte.
                state_q <= ST_RX;
                bit_cnt_q <= 4'h0;
                byte_idx_q <= 2'd0;
                oe_q <= 1'b0;
            end else if (bus_stop) begin
                state_q <= ST_IDLE;
                oe_q <= 1'b0;
            end else begin
                unique case (state_q)
                    // Bus free or not ours.
                    ST_IDLE: begin
                        oe_q <= 1'b0;
                    end

                    // Shifts in a byte.
                    ST_RX: begin
                        if (scl_rise && bit_cnt_q != BYTE_BITS) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (byte_done) begin
                            if (byte_idx_q == 2'd0 && !addr_match) begin
                                state_q <= ST_IDLE;
                            end else begin
                                // Acknowledge the byte by pulling data low.
                                state_q <= ST_RACK;
                                oe_q <= 1'b1;

                                unique case (byte_idx_q)
                                    2'd0: reading_q <= shift_q[0];
                                    2'd1: cmd_q <= shift_q;
                                    2'd2: low_q <= shift_q;
                                    default: begin
                                        wdata_q <= {shift_q, low_q};
                                        wr_q <= 1'b1;
                                    end
                                endcase

                                if (byte_idx_q != 2'd3) begin
                                    byte_idx_q <= byte_idx_q + 2'd1;
                                end

                                if (read_load) begin
                                    // Low byte goes out first.
                                    tx_q <= {acc.rdata[7:0], acc.rdata[15:8]};
                                end
                            end
                        end
                    end

                    // Holds the acknowledge.
                    ST_RACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= 4'h0;

                            if (reading_q) begin
                                state_q <= ST_TX;
                                second_q <= 1'b0;
                                oe_q <= !tx_q[15];
                                tx_q <= {tx_q[14:0], 1'b0};
                                bit_cnt_q <= 4'h1;
                            end else begin
                                state_q <= ST_RX;
                                oe_q <= 1'b0;
                            end
                        end
                    end

                    // Shifts out a byte.
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_q == BYTE_BITS) begin
                                // Release data for the host's acknowledge.
                                state_q <= ST_TACK;
                                oe_q <= 1'b0;
                            end else begin
                                oe_q <= !tx_q[15];
                                tx_q <= {tx_q[14:0], 1'b0};
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end

                    // Reads the host's acknowledge.
                    ST_TACK: begin
                        if (scl_rise) begin
                            acked_q <= !sda_s;
                        end else if (scl_fall) begin
                            if (acked_q && !second_q) begin
                                state_q <= ST_TX;
                                second_q <= 1'b1;
                                oe_q <= !tx_q[15];
                                tx_q <= {tx_q[14:0], 1'b0};
                                bit_cnt_q <= 4'h1;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end

                    default: begin
                        state_q <= ST_IDLE;
                        oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Strobes and data toward the register bank.
    assign acc.cmd = cmd_q;
    assign acc.rd = read_load && ce;
    assign acc.wr = wr_q && ce;
    assign acc.wdata = wdata_q;

    // Open drain: the pin is only ever pulled low.
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
endmodule
`default_nettype wire

// ===== rtl/charger_status_pkg.sv
`default_nettype none
package charger_status_pkg;
    // Bus target address; the value is arbitrary.
    localparam logic [6:0] TARGET_ADDR = 7'h09;
    // Command codes.
    localparam logic [7:0] CMD_CHARGER_STATE = 8'h20;
    localparam logic [7:0] CMD_THROTTLE_TRIGGER = 8'h21;
    // Reset values.
    localparam logic [15:0] CHARGER_STATE_RESET = 16'h0000;
    localparam logic [15:0] THROTTLE_TRIGGER_RESET = 16'h0000;
    // Field layout of the charger state word.
    localparam int BIT_INPUT_PRESENT = 15;
    localparam int BIT_OPTIMISE_DONE = 14;
    localparam int BIT_VOLTAGE_REG = 12;
    localparam int BIT_CURRENT_REG = 11;
    localparam int BIT_FAST_CHARGE = 10;
    localparam int BIT_PRECHARGE = 9;
    localparam int BIT_REVERSE = 8;
    localparam int BIT_INPUT_OV = 7;
    localparam int BIT_BATTERY_OC = 6;
    localparam int BIT_INPUT_OC = 5;
    localparam int BIT_SYSTEM_OV = 4;
    localparam int BIT_LATCHOFF = 2;
    localparam int BIT_REVERSE_OV = 1;
    localparam int BIT_REVERSE_OC = 0;
    localparam logic [15:0] LIVE_MASK = 16'hDF00;
    localparam logic [15:0] FAULT_MASK = 16'h00E7;
    localparam logic [15:0] TRIGGER_MASK = 16'h007F;
    localparam int TRIGGER_COUNT = 7;
    // Synchroniser width: scl, sda, 7 live, 6 faults, overvoltage, 7 triggers.
    localparam int SYNC_WIDTH = 23;
    // Bit count of one bus byte.
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Protocol engine states.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX = 5'b00010,
        ST_RACK = 5'b00100,
        ST_TX = 5'b01000,
        ST_TACK = 5'b10000
    } bus_state_type;
endpackage
`default_nettype wire

// ===== rtl/status_access_if.sv
`default_nettype none
// Register access strobes from the bus engine to the register bank.
interface status_access_if;
    logic [7:0] cmd;
    logic rd;
    logic wr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport engine (output cmd, output rd, output wr, output wdata, input rdata);
    modport bank (input cmd, input rd, input wr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== rtl/input_sync.sv
`default_nettype none
module input_sync
    import charger_status_pkg::*;
#(
    parameter int WIDTH = SYNC_WIDTH
) (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Asynchronous inputs and their synchronised copies.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // Two flip-flops per bit; only the second stage is read outside.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/status_bank.sv
`default_nettype none
module status_bank
    import charger_status_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Synchronised status placed at their word positions.
    input wire logic [15:0] live_word,
    input wire logic [15:0] fault_events,
    input wire logic system_ov_detect,
    input wire logic [TRIGGER_COUNT-1:0] trigger_events,
    // Register access.
    status_access_if.bank acc,
    // Converter enable.
    output logic converter_enable
);
    logic [15:0] fault_q;
    logic system_ov_q;
    logic [TRIGGER_COUNT-1:0] trigger_q;
    logic charger_read;
    logic trigger_read;
    logic ov_clear;

    // Access decode; writes to every other bit or word have no effect.
    assign charger_read = acc.rd && (acc.cmd == CMD_CHARGER_STATE);
    assign trigger_read = acc.rd && (acc.cmd == CMD_THROTTLE_TRIGGER);
    assign ov_clear = (acc.wr && (acc.cmd == CMD_CHARGER_STATE) && !acc.wdata[BIT_SYSTEM_OV])
        || !live_word[BIT_INPUT_PRESENT];

    // Fault flags clear on a host read; a new event in that cycle wins.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_q <= CHARGER_STATE_RESET;
        end else if (ce) begin
            fault_q <= ((charger_read ? 16'h0000 : fault_q) | fault_events) & FAULT_MASK;
        end
    end

    // System overvoltage latch; the live condition overrides any clear.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            system_ov_q <= 1'b0;
        end else if (ce) begin
            system_ov_q <= system_ov_detect || (system_ov_q && !ov_clear);
        end
    end

    // Throttle trigger flags hold until the word is read.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trigger_q <= THROTTLE_TRIGGER_RESET[TRIGGER_COUNT-1:0];
        end else if (ce) begin
            trigger_q <= (trigger_read ? '0 : trigger_q) | trigger_events;
        end
    end

    // Read multiplexer; reserved bits and unmapped commands read zero.
    always_comb begin
        acc.rdata = 16'h0000;
        if (acc.cmd == CMD_CHARGER_STATE) begin
            acc.rdata = (live_word & LIVE_MASK) | fault_q;
            acc.rdata[BIT_SYSTEM_OV] = system_ov_q;
        end else if (acc.cmd == CMD_THROTTLE_TRIGGER) begin
            acc.rdata = {9'h000, trigger_q} & TRIGGER_MASK;
        end
    end

    // The converter runs only while the latch is clear.
    assign converter_enable = !system_ov_q;
endmodule
`default_nettype wire

// ===== sim/charger_status_flags_props.sv
`default_nettype none
module charger_status_flags_props (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Bus pins and power stage.
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic input_good_pin,
    input wire logic system_overvoltage_detect,
    input wire logic converter_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Port checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Overvoltage held long enough to pass the synchronisers.
    sequence ovp_held;
        (ce && system_overvoltage_detect) [*3];
    endsequence
    // Adapter gone and no overvoltage, long enough to pass the synchronisers.
    sequence unplugged;
        (ce && !input_good_pin && !system_overvoltage_detect) [*4];
    endsequence
    // Converter off with the adapter present and the bus idle.
    sequence idle_latched;
        (!converter_enable && input_good_pin && scl_in && sda_in) [*8];
    endsequence
    ovp_disable_a: assert property (ovp_held |=> !converter_enable)
        else $error("converter enabled during overvoltage");
    enable_fall_a: assert property ($fell(converter_enable) |-> $past(system_overvoltage_detect, 3))
        else $error("converter disabled without overvoltage");
    enable_rise_a: assert property ($rose(converter_enable) |-> !$past(system_overvoltage_detect, 3))
        else $error("converter enabled while overvoltage present");
    unplug_clear_a: assert property (unplugged |=> converter_enable)
        else $error("adapter removal did not clear the latch");
    latch_hold_a: assert property (idle_latched |=> !converter_enable)
        else $error("latch cleared without host write or unplug");
    reset_state_a: assert property ($rose(reset_n) |-> converter_enable && !sda_oe)
        else $error("wrong pin state after reset");
    oe_stable_a: assert property (scl_in [*4] |-> $stable(sda_oe))
        else $error("data drive changed while clock high");
    oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("data drive started outside clock low");
    drive_low_a: assert property (sda_oe |-> !sda_out)
        else $error("open drain output drives high");
endmodule
bind charger_status_flags charger_status_flags_props i_props (.clk(clk), .reset_n(reset_n), .ce(ce),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .input_good_pin(input_good_pin),
    .system_overvoltage_detect(system_overvoltage_detect), .converter_enable(converter_enable));
`default_nettype wire

// ===== sim/smbus_host_model.sv
`default_nettype none
module smbus_host_model
    import charger_status_pkg::*;
(
    // Clock and the wired data line.
    input wire logic clk,
    input wire logic sda_line,
    // Host clock level and data pull-down.
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Bus host
    // ----------------------------------------
    // Clocks per bus phase; raised by the bench for a slow host.
    int half = 4;
    // Bus idles released.
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    // Waits one bus phase.
    task automatic phase();
        repeat (half) @(posedge clk);
    endtask
    // One bit: data set while clock is low, sampled at the end of the high phase.
    task automatic bit_cycle(input logic b, output logic r);
        sda_low <= !b;
        phase();
        scl <= 1'h1;
        phase();
        r = sda_line;
        scl <= 1'h0;
        phase();
    endtask
    // Eight bits MSB first, then the acknowledge bit.
    task automatic byte_cycle(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(tx[i], rx[i]);
        end
        bit_cycle(ack_in, ack);
    endtask
    // Start or repeated start: data falls while the clock is high.
    task automatic start_cond();
        sda_low <= 1'h0;
        phase();
        scl <= 1'h1;
        phase();
        sda_low <= 1'h1;
        phase();
        scl <= 1'h0;
        phase();
    endtask
    // Stop: data rises while the clock is high.
    task automatic stop_cond();
        sda_low <= 1'h1;
        phase();
        scl <= 1'h1;
        phase();
        sda_low <= 1'h0;
        phase();
    endtask
    // Word write, low byte first; nack is high if any byte was refused.
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] data, output logic nack);
        logic [7:0] rx;
        logic [3:0] a;
        start_cond();
        byte_cycle({TARGET_ADDR, 1'h0}, 1'h1, rx, a[0]);
        byte_cycle(cmd, 1'h1, rx, a[1]);
        byte_cycle(data[7:0], 1'h1, rx, a[2]);
        byte_cycle(data[15:8], 1'h1, rx, a[3]);
        stop_cond();
        nack = |a;
    endtask
    // Word read with repeated start; the host acks the low byte and refuses the high one.
    task automatic read_word(input logic [6:0] addr, input logic [7:0] cmd, output logic [15:0] data,
                             output logic nack);
        logic [7:0] rx;
        logic [2:0] a;
        logic dummy;
        start_cond();
        byte_cycle({addr, 1'h0}, 1'h1, rx, a[0]);
        byte_cycle(cmd, 1'h1, rx, a[1]);
        start_cond();
        byte_cycle({addr, 1'h1}, 1'h1, rx, a[2]);
        byte_cycle(8'hFF, 1'h0, data[7:0], dummy);
        byte_cycle(8'hFF, 1'h1, data[15:8], dummy);
        stop_cond();
        nack = |a;
    endtask
endmodule
`default_nettype wire

// ===== sim/test_charger_status_flags.sv
`default_nettype none
`define CHECK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_charger_status_flags
    import charger_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    logic clk, reset_n, ce, scl, host_low, sda_oe, sda_out, conv_en, sov;
    logic [6:0] live, trig;
    logic [5:0] flt;
    int error_cnt = 0;
    int total_checks = 0;
    // Open-drain data line with pull-up.
    wire sda_line = !(host_low || sda_oe);
    charger_status_flags i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .input_good_pin(live[6]), .current_optimise_done(live[5]),
        .input_voltage_regulating(live[4]), .input_current_regulating(live[3]), .fast_charge_active(live[2]),
        .precharge_active(live[1]), .reverse_supply_active(live[0]), .input_overvoltage_fault(flt[5]),
        .battery_overcurrent_fault(flt[4]), .input_overcurrent_fault(flt[3]), .latchoff_fault(flt[2]),
        .reverse_overvoltage_fault(flt[1]), .reverse_overcurrent_fault(flt[0]),
        .system_overvoltage_detect(sov), .throttle_trigger_in(trig), .converter_enable(conv_en));
    smbus_host_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));
    // Expected word from the live indications.
    function automatic logic [15:0] live_word(input logic [6:0] v);
        return {v[6:5], 1'h0, v[4:0], 8'h00};
    endfunction
    // Expected word from the latched faults.
    function automatic logic [15:0] fault_word(input logic [5:0] f);
        return {8'h00, f[5:3], 2'h0, f[2:0]};
    endfunction
    // Reads a word and compares it.
    task automatic rd(input logic [7:0] cmd, input logic [15:0] ex);
        logic [15:0] got;
        logic nk;
        i_host.read_word(TARGET_ADDR, cmd, got, nk);
        `CHECK("read ack", 1'h0, nk)
        `CHECK("read word", ex, got)
    endtask
    // Writes a word and checks it was acknowledged.
    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        logic nk;
        i_host.write_word(cmd, data, nk);
        `CHECK("write ack", 1'h0, nk)
    endtask
    // Holds the overvoltage input at a level for some cycles.
    task automatic ovp(input logic lvl);
        @(posedge clk);
        sov <= lvl;
        repeat (10) @(posedge clk);
    endtask
    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Clock of 50 ns period.
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // Watchdog against a hung bus.
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    // Main sequence.
    initial begin
        logic [6:0] v;
        logic [5:0] f;
        logic [15:0] w;
        logic nk;
        reset_n = 1'h0;
        ce = 1'h1;
        live = 7'h00;
        flt = 6'h00;
        sov = 1'h0;
        trig = 7'h00;
        v = 7'($urandom(78));
        repeat (16) @(posedge clk);
        reset_n <= 1'h1;
        repeat (4) @(posedge clk);
        `CHECK("converter enable", 1'h1, conv_en)
        rd(CMD_CHARGER_STATE, 16'h0000);
        rd(CMD_THROTTLE_TRIGGER, 16'h0000);
        i_host.read_word(TARGET_ADDR ^ 7'h01, CMD_CHARGER_STATE, w, nk);
        `CHECK("foreign address nack", 1'h1, nk)
        // Live indications at host speeds from prompt to slow.
        for (int n = 0; n < 8; n++) begin
            v = (n == 0) ? 7'h7F : 7'($urandom());
            i_host.half = 4 + (n % 4);
            @(posedge clk);
            live <= v;
            repeat (4) @(posedge clk);
            rd(CMD_CHARGER_STATE, live_word(v));
        end
        i_host.half = 5;
        // Fault pulses latch and clear on read.
        for (int n = 0; n < 6; n++) begin
            f = (n == 0) ? 6'h3F : 6'($urandom());
            @(posedge clk);
            live <= 7'h00;
            flt <= f;
            @(posedge clk);
            flt <= 6'h00;
            rd(CMD_CHARGER_STATE, fault_word(f));
            rd(CMD_CHARGER_STATE, 16'h0000);
        end
        // A fault still present across the clearing read is kept.
        @(posedge clk);
        flt <= 6'h21;
        rd(CMD_CHARGER_STATE, fault_word(6'h21));
        rd(CMD_CHARGER_STATE, fault_word(6'h21));
        @(posedge clk);
        flt <= 6'h00;
        rd(CMD_CHARGER_STATE, fault_word(6'h21));
        rd(CMD_CHARGER_STATE, 16'h0000);
        // Throttle triggers latch, clear on read and ignore writes.
        for (int n = 0; n < 4; n++) begin
            v = (n == 0) ? 7'h7F : 7'($urandom());
            @(posedge clk);
            trig <= v;
            @(posedge clk);
            trig <= 7'h00;
            rd(CMD_THROTTLE_TRIGGER, {9'h000, v});
            wr(CMD_THROTTLE_TRIGGER, 16'hFFFF);
            rd(CMD_THROTTLE_TRIGGER, 16'h0000);
        end
        // System overvoltage latch with the adapter present.
        @(posedge clk);
        live <= 7'h40;
        ovp(1'h1);
        `CHECK("converter enable", 1'h0, conv_en)
        wr(CMD_CHARGER_STATE, 16'h0000);
        rd(CMD_CHARGER_STATE, 16'h8010);
        ovp(1'h0);
        `CHECK("converter enable", 1'h0, conv_en)
        wr(CMD_CHARGER_STATE, 16'h0010);
        wr(CMD_CHARGER_STATE, 16'hFFFF);
        rd(CMD_CHARGER_STATE, 16'h8010);
        wr(CMD_CHARGER_STATE, 16'hFFEF);
        rd(CMD_CHARGER_STATE, 16'h8000);
        `CHECK("converter enable", 1'h1, conv_en)
        // Adapter removal clears the latch once overvoltage is gone.
        ovp(1'h1);
        ovp(1'h0);
        `CHECK("converter enable", 1'h0, conv_en)
        @(posedge clk);
        live <= 7'h00;
        repeat (6) @(posedge clk);
        `CHECK("converter enable", 1'h1, conv_en)
        rd(CMD_CHARGER_STATE, 16'h0000);
        print_verdict();
    end
endmodule
`default_nettype wire
